/* src/ats_pkg.sv */
// Shared constants, field layout and symbol encoder for the front-end link
package ats_pkg;
   // ---------------------------------------------------------------
   // Frame timing
   // ---------------------------------------------------------------
   localparam int MASTER_CLK_KHZ = 15360;
   localparam int FRAME_RATE_KHZ = 80;
   localparam logic [7:0] FRAME_BITS = 8'(MASTER_CLK_KHZ / FRAME_RATE_KHZ);
   localparam logic [7:0] FRAME_LAST = FRAME_BITS - 8'h01;
   localparam logic [3:0] NUM_SLOTS = 4'h9;
   localparam logic [3:0] SLOT_LAST = NUM_SLOTS - 4'h1;
   localparam logic [4:0] DATA_SLOT_BITS = 5'h15;
   localparam logic [4:0] SYNC_SLOT_BITS = 5'h18;
   localparam logic [4:0] LD_BITS = 5'h14;
   localparam logic [4:0] LD_FIRST = DATA_SLOT_BITS - LD_BITS;
   localparam logic [4:0] DATA_SLOT_LAST = DATA_SLOT_BITS - 5'h01;
   localparam logic [4:0] SYNC_SLOT_LAST = SYNC_SLOT_BITS - 5'h01;
   localparam int NUM_PORTS = 4;
   localparam int LINK_LAT = 3;

   // ---------------------------------------------------------------
   // Transmit slot field positions, first bit sent is bit 0
   // ---------------------------------------------------------------
   localparam int BIT_MARKER = 0;
   localparam int BIT_UPDATE = 1;
   localparam int BIT_PD = 2;
   localparam int BIT_RANGE = 3;
   localparam int BIT_LOOP = 4;
   localparam int BIT_ZERO_SEL = 5;
   localparam int BIT_SIGN = 6;
   localparam int BIT_MAG = 7;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SYM = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_ADC = 8'h0c;
   localparam logic [11:0] CTRL_RESET = 12'h249;
   localparam logic [3:0] PEND_RESET = 4'hf;
   localparam int ST_WAKE = 0;
   localparam int ST_LD = 4;
   localparam int ST_MERR = 8;
   localparam int ST_OVF = 9;
   localparam int ST_FULL = 10;
   localparam int ST_PEND = 12;
   localparam int ST_LEVEL = 16;

   // ---------------------------------------------------------------
   // Symbol buffer
   // ---------------------------------------------------------------
   localparam int SYM_W = 12;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_AW = 3;
   localparam logic [2:0] CODE_ZERO = 3'h4;
   localparam logic [11:0] SYM_IDLE = {4{CODE_ZERO}};

   // Signed level in, 3-bit line code out {zero_select, sign, magnitude}
   function automatic logic [2:0] ats_encode(input logic [2:0] lvl);
      logic [2:0] code;
      code = CODE_ZERO;
      case (lvl)
         3'h5: code = 3'h0;
         3'h7: code = 3'h1;
         3'h3: code = 3'h2;
         3'h1: code = 3'h3;
         default: code = CODE_ZERO;
      endcase
      return code;
   endfunction
endpackage

/* src/ats_fifo.sv */
// Symbol buffer between the register port and the frame builder
module ats_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [AW:0] level
);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   assign in_ready = (count_ff != (AW+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data = mem_ff[rd_ptr_ff];
   assign level = count_ff;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + AW'(1);
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + AW'(1);
         end
         if (push && !pop) begin
            count_ff <= count_ff + (AW+1)'(1);
         end else if (pop && !push) begin
            count_ff <= count_ff - (AW+1)'(1);
         end
      end
   end
endmodule // ats_fifo

/* src/ats_link.sv */
// Frame builder and status receiver of the six-wire analog front-end link
//
// How it works
// RULE_01 - Everything timed by the one core clock
// RULE_02 - Frame is exactly 192 bit times
// RULE_03 - Nine slots: eight of 21, one of 24
// RULE_04 - Only odd slots carry ports 0 to 3
// RULE_05 - Status slot aligned, level bit in last 20
// RULE_06 - No change: update flag and controls zero
// RULE_07 - On change: flag one plus all controls
// RULE_08 - Power-down bit one powers port down
// RULE_09 - Range bit one enables short-line attenuation
// RULE_10 - Loop bit one closes analog loopback
// RULE_11 - Slot marker one outbound, zero inbound
// RULE_12 - Reserved transmit bits always zero
// RULE_13 - Symbols coded in three bits, top first
// RULE_14 - Level bit toggles when signal is present
// RULE_15 - Four bitstream inputs carry converter data
// RULE_16 - Level bit change per frame means wake
module ats_link (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic [ats_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [ats_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [ats_pkg::DATA_W-1:0] REG_RDATA,
   output logic SERIAL_CTRL_TO_FRONTEND,
   input wire logic SERIAL_STATUS_FROM_FRONTEND,
   input wire logic [ats_pkg::NUM_PORTS-1:0] ADC_BITSTREAM_INPUTS,
   output logic [ats_pkg::NUM_PORTS-1:0] WAKE_LEVEL,
   output logic FRAME_START,
   output logic TX_READY
);
   import ats_pkg::*;

   logic [7:0] pos_ff;
   logic [3:0] slot_ff, pend_ff, rx_slot, ld_ff, wake_ff, adc_meta_ff, adc_sync_ff;
   logic [4:0] bit_ff, rx_bit;
   logic [11:0] ctrl_ff;
   logic [SYM_W-1:0] sym_ff, push_word, fifo_out_data;
   logic [DATA_SLOT_BITS-1:0] word_ff, slot_word;
   logic [1:0] tx_port;
   logic slot_end, ser_ff, frame_ff, tx_ready_ff, slot_load, wr_ctrl, wr_sym, wr_status;
   logic fifo_in_ready, fifo_out_valid, pop_sym, st_meta_ff, st_sync_ff, merr_ff, ovf_ff;
   logic [FIFO_AW:0] fifo_level;
   logic [LINK_LAT-1:0][3:0] slot_pipe_ff;
   logic [LINK_LAT-1:0][4:0] bit_pipe_ff;
   logic [NUM_PORTS-1:0][7:0] adc_cnt_ff, adc_lat_ff;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;

   // ---------------------------------------------------------------
   // Frame and slot counters
   // ---------------------------------------------------------------
   // The core clock is the link bit clock, one bit per edge (see RULE_01)
   assign slot_end = (slot_ff == 4'h0) ? (bit_ff == SYNC_SLOT_LAST) : (bit_ff == DATA_SLOT_LAST); // see RULE_03

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         pos_ff <= 8'h00;
      end else begin
         pos_ff <= (pos_ff == FRAME_LAST) ? 8'h00 : pos_ff + 8'h01; // see RULE_02
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         slot_ff <= 4'h0;
         bit_ff <= 5'h00;
      end else if (slot_end) begin
         bit_ff <= 5'h00;
         slot_ff <= (slot_ff == SLOT_LAST) ? 4'h0 : slot_ff + 4'h1; // see RULE_03
      end else begin
         bit_ff <= bit_ff + 5'h01;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         frame_ff <= 1'b0;
      end else begin
         frame_ff <= (pos_ff == FRAME_LAST);
      end
   end

   // ---------------------------------------------------------------
   // Register port decode
   // ---------------------------------------------------------------
   assign wr_ctrl = REG_WR && (REG_ADDR == ADDR_CTRL);
   assign wr_sym = REG_WR && (REG_ADDR == ADDR_SYM);
   assign wr_status = REG_WR && (REG_ADDR == ADDR_STATUS);

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         ctrl_ff <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_ff <= REG_WDATA[11:0]; // see RULE_08 RULE_09 RULE_10
      end
   end

   // ---------------------------------------------------------------
   // Control update tracking, a write that races the slot load wins
   // ---------------------------------------------------------------
   assign tx_port = slot_ff[2:1]; // see RULE_04
   assign slot_load = slot_ff[0] && (bit_ff == 5'h00);

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_pend
      logic chg;
      logic clr;
      assign chg = wr_ctrl && (REG_WDATA[3*p +: 3] != ctrl_ff[3*p +: 3]);
      assign clr = slot_load && (tx_port == 2'(p));
      always_ff @(posedge CORE_CLK) begin
         if (!RST_B) begin
            pend_ff[p] <= PEND_RESET[p];
         end else begin
            pend_ff[p] <= chg | (pend_ff[p] & ~clr); // see RULE_07
         end
      end
   end

   // ---------------------------------------------------------------
   // Symbol buffer, one word of four symbols per frame
   // ---------------------------------------------------------------
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_enc
      assign push_word[3*p +: 3] = ats_encode(REG_WDATA[4*p +: 3]); // see RULE_13
   end

   assign pop_sym = (pos_ff == 8'h00);

   ats_fifo #(
      .WIDTH(SYM_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .in_valid(wr_sym),
      .in_ready(fifo_in_ready),
      .in_data(push_word),
      .out_valid(fifo_out_valid),
      .out_ready(pop_sym),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   // An empty buffer sends zero symbols rather than repeating stale ones
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         sym_ff <= SYM_IDLE;
      end else if (pop_sym) begin
         sym_ff <= fifo_out_valid ? fifo_out_data : SYM_IDLE; // see RULE_13
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         tx_ready_ff <= 1'b0;
         ovf_ff <= 1'b0;
      end else begin
         tx_ready_ff <= fifo_in_ready;
         ovf_ff <= (wr_sym && !fifo_in_ready) | (ovf_ff & ~(wr_status && REG_WDATA[ST_OVF]));
      end
   end

   // ---------------------------------------------------------------
   // Transmit slot assembly
   // ---------------------------------------------------------------
   always_comb begin
      slot_word = '0; // see RULE_12
      slot_word[BIT_MARKER] = 1'b1; // see RULE_11
      slot_word[BIT_UPDATE] = pend_ff[tx_port];
      if (pend_ff[tx_port]) begin
         slot_word[BIT_PD] = ctrl_ff[3*tx_port]; // see RULE_07 RULE_08
         slot_word[BIT_RANGE] = ctrl_ff[3*tx_port+1]; // see RULE_09
         slot_word[BIT_LOOP] = ctrl_ff[3*tx_port+2]; // see RULE_10
      end
      // Idle controls stay low to keep digital noise off the analog side (see RULE_06)
      slot_word[BIT_ZERO_SEL] = sym_ff[3*tx_port+2]; // see RULE_13
      slot_word[BIT_SIGN] = sym_ff[3*tx_port+1];
      slot_word[BIT_MAG] = sym_ff[3*tx_port];
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         word_ff <= '0;
      end else if (slot_load) begin
         word_ff <= slot_word;
      end
   end

   // Unused and sync slots are driven low (see RULE_04)
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         ser_ff <= 1'b0;
      end else if (!slot_ff[0]) begin
         ser_ff <= 1'b0; // see RULE_12
      end else begin
         ser_ff <= (bit_ff == 5'h00) ? slot_word[0] : word_ff[bit_ff];
      end
   end

   // ---------------------------------------------------------------
   // Status line receive
   // ---------------------------------------------------------------
   // Output flop plus two sync flops: the slot position is delayed to match
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         st_meta_ff <= 1'b0;
         st_sync_ff <= 1'b0;
         slot_pipe_ff <= '0;
         bit_pipe_ff <= '0;
      end else begin
         st_meta_ff <= SERIAL_STATUS_FROM_FRONTEND;
         st_sync_ff <= st_meta_ff;
         slot_pipe_ff <= {slot_pipe_ff[LINK_LAT-2:0], slot_ff}; // see RULE_05
         bit_pipe_ff <= {bit_pipe_ff[LINK_LAT-2:0], bit_ff};
      end
   end

   assign rx_slot = slot_pipe_ff[LINK_LAT-1];
   assign rx_bit = bit_pipe_ff[LINK_LAT-1];

   // Sampled on the last bit of the slot, which lies in the level window
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_rx
      logic hit;
      assign hit = rx_slot[0] && (rx_slot[2:1] == 2'(p)) && (rx_bit == DATA_SLOT_LAST);
      always_ff @(posedge CORE_CLK) begin
         if (!RST_B) begin
            ld_ff[p] <= 1'b0;
            wake_ff[p] <= 1'b0;
         end else if (hit) begin
            ld_ff[p] <= st_sync_ff; // see RULE_05 RULE_14
            wake_ff[p] <= st_sync_ff ^ ld_ff[p]; // see RULE_16
         end
      end
   end

   // A high marker on the status line means the link is misaligned
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         merr_ff <= 1'b0;
      end else begin
         merr_ff <= (rx_slot[0] && (rx_bit == 5'h00) && st_sync_ff) // see RULE_11
                    | (merr_ff & ~(wr_status && REG_WDATA[ST_MERR]));
      end
   end

   // ---------------------------------------------------------------
   // Converter bitstreams: ones counted over each frame
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         adc_meta_ff <= 4'h0;
         adc_sync_ff <= 4'h0;
      end else begin
         adc_meta_ff <= ADC_BITSTREAM_INPUTS; // see RULE_15
         adc_sync_ff <= adc_meta_ff;
      end
   end

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_adc
      always_ff @(posedge CORE_CLK) begin
         if (!RST_B) begin
            adc_cnt_ff[p] <= 8'h00;
            adc_lat_ff[p] <= 8'h00;
         end else if (pos_ff == FRAME_LAST) begin
            adc_lat_ff[p] <= adc_cnt_ff[p] + {7'h00, adc_sync_ff[p]}; // see RULE_15
            adc_cnt_ff[p] <= 8'h00;
         end else begin
            adc_cnt_ff[p] <= adc_cnt_ff[p] + {7'h00, adc_sync_ff[p]};
         end
      end
   end

   // ---------------------------------------------------------------
   // Read data, valid in the cycle after the strobe only
   // ---------------------------------------------------------------
   always_comb begin
      nxt_rdata = '0;
      if (REG_RD) begin
         case (REG_ADDR)
            ADDR_CTRL: nxt_rdata[11:0] = ctrl_ff;
            ADDR_SYM: nxt_rdata[FIFO_AW:0] = fifo_level;
            ADDR_STATUS: begin
               nxt_rdata[ST_WAKE +: 4] = wake_ff;
               nxt_rdata[ST_LD +: 4] = ld_ff;
               nxt_rdata[ST_MERR] = merr_ff;
               nxt_rdata[ST_OVF] = ovf_ff;
               nxt_rdata[ST_FULL] = !fifo_in_ready;
               nxt_rdata[ST_PEND +: 4] = pend_ff;
               nxt_rdata[ST_LEVEL +: FIFO_AW+1] = fifo_level;
            end
            ADDR_ADC: nxt_rdata = adc_lat_ff;
            default: nxt_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign REG_RDATA = rdata_ff;
   assign SERIAL_CTRL_TO_FRONTEND = ser_ff;
   assign WAKE_LEVEL = wake_ff;
   assign FRAME_START = frame_ff;
   assign TX_READY = tx_ready_ff;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);

   frame_wrap_a: assert property ((pos_ff == FRAME_LAST) |=> (pos_ff == 8'h00) && (slot_ff == 4'h0) && (bit_ff == 5'h00)) // see RULE_02
      else $error("frame did not wrap after 192 bits");
   slot_len_a: assert property ((slot_ff == 4'h1) && (bit_ff == 5'h00) |-> (pos_ff == 8'h18)) // see RULE_03
      else $error("sync slot length wrong");
   marker_out_a: assert property (slot_load |=> SERIAL_CTRL_TO_FRONTEND) // see RULE_11
      else $error("slot marker not driven high");
   unused_low_a: assert property (!slot_ff[0] |=> !SERIAL_CTRL_TO_FRONTEND) // see RULE_04
      else $error("unused slot not low");
   idle_ctrl_a: assert property (slot_load && !pend_ff[tx_port] |=> ##1 !SERIAL_CTRL_TO_FRONTEND [*4]) // see RULE_06
      else $error("idle control bits not low");
   update_flag_a: assert property (slot_load && pend_ff[tx_port] |=> ##1 SERIAL_CTRL_TO_FRONTEND) // see RULE_07
      else $error("update flag not sent");
   pend_clear_a: assert property (slot_load && pend_ff[tx_port] && !wr_ctrl |=> !pend_ff[$past(tx_port)]) // see RULE_07
      else $error("pending update not cleared");
   pd_bit_a: assert property (slot_load && pend_ff[tx_port] |=> ##2 (SERIAL_CTRL_TO_FRONTEND == $past(ctrl_ff[3*tx_port], 3))) // see RULE_08
      else $error("power-down bit wrong");
   zero_sym_a: assert property (slot_load && sym_ff[3*tx_port+2] |=> ##5 SERIAL_CTRL_TO_FRONTEND) // see RULE_13
      else $error("zero symbol select not sent");
   wake_a: assert property (g_rx[0].hit |=> (wake_ff[0] == ($past(st_sync_ff) ^ $past(ld_ff[0])))) // see RULE_16
      else $error("wake decision wrong");
   read_ctrl_a: assert property (REG_RD && (REG_ADDR == ADDR_CTRL) |=> (REG_RDATA[11:0] == $past(ctrl_ff))) // see RULE_08
      else $error("control read back wrong");
endmodule // ats_link

/* tb/ats_afe_model.sv */
// Behavioural analog front end facing the serial lines of the link
module ats_afe_model
   import ats_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic frame_start,
   input wire logic ser_in,
   input wire logic [3:0] wake_on,
   input wire logic [31:0] ones,
   output logic status_out,
   output logic [3:0] adc_out,
   output logic [11:0] ctrl_q,
   output logic [15:0] errs
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] q;
   logic [7:0] nq;
   logic [11:0] codes;
   logic [3:0] ld;
   logic flag;
   logic [11:0] hist [$];

   // Offset inside a used slot, or -1 anywhere else
   function automatic int slot_off(input logic [7:0] p, output int port);
      int k;
      k = (int'(p) - 24) / 21;
      port = k / 2;
      if (p < 8'h18 || k % 2 != 0) return -1;
      return (int'(p) - 24) % 21;
   endfunction

   // q is the frame position of the bit now on the pin
   always_comb nq = (frame_start || q == 8'hbf) ? 8'h00 : q + 8'h01;

   always @(posedge clk) begin
      int off;
      int p;
      int on;
      int pn;
      off = slot_off(q, p);
      on = slot_off(nq, pn);
      if (!rst_b) begin
         q <= 8'hbf;
         errs <= '0;
         ld <= '0;
         flag <= 1'b0;
         ctrl_q <= '0;
         codes <= '0;
         status_out <= 1'b0;
         adc_out <= '0;
      end else begin
         q <= nq;
         // The link leaves reset at position 0 and the model at 0xbf, the bit then on the pin, so the first frame's updates are judged too
         case (off)
            0: if (ser_in !== 1'b1) errs <= errs + 16'h1;
            1: flag <= ser_in;
            2, 3, 4: if (flag) ctrl_q[3*p+off-2] <= ser_in;
               else if (ser_in !== 1'b0) errs <= errs + 16'h1;
            5, 6, 7: codes[3*p+7-off] <= ser_in;
            default: if (ser_in !== 1'b0) errs <= errs + 16'h1;
         endcase
         if (q == 8'hbf) begin
            hist.push_back(codes);
            ld <= ld ^ wake_on;
         end
         status_out <= (on > 0) ? ld[pn] : 1'b0;
         for (int i = 0; i < 4; i++) adc_out[i] <= nq < ones[8*i+:8];
      end
   end
endmodule // ats_afe_model

/* tb/test_ats_link.sv */
// Self-checking bench for the link: registers, frames, symbols, status
module test_ats_link;
   timeunit 1ns;
   timeprecision 100ps;
   import ats_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic ser_out;
   logic ser_in;
   logic fstart;
   logic tx_ready;
   logic [3:0] adc;
   logic [3:0] wake;
   logic [3:0] wake_on = 4'h0;
   logic [11:0] ctrl_seen;
   logic [15:0] errs;
   logic [31:0] d;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;

   always #25 clk = ~clk;

   ats_link dut_u (.CORE_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s),
      .REG_RD(rd_s), .REG_RDATA(rdata), .SERIAL_CTRL_TO_FRONTEND(ser_out), .SERIAL_STATUS_FROM_FRONTEND(ser_in),
      .ADC_BITSTREAM_INPUTS(adc), .WAKE_LEVEL(wake), .FRAME_START(fstart), .TX_READY(tx_ready));
   ats_afe_model afe_u (.clk(clk), .rst_b(rst_b), .frame_start(fstart), .ser_in(ser_out), .wake_on(wake_on),
      .ones(32'hc0402010), .status_out(ser_in), .adc_out(adc), .ctrl_q(ctrl_seen), .errs(errs));

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask

   // Returns at the edge that closes the cycle with counter position 0
   task automatic frames(input int n);
      repeat (n) begin
         @(posedge clk);
         for (int i = 0; i < 200 && fstart !== 1'b1; i++) @(posedge clk);
      end
   endtask

   task automatic t_reset;
      rd(ADDR_CTRL);
      chk(d, 32'h249);
      @(posedge clk);
      chk(rdata, 32'h0);
      rd(ADDR_STATUS);
      chk(d[15:12], 4'hf);
      rd(8'h10);
      chk(d, 32'h0);
      chk(tx_ready, 1'b1);
      $display("test reset done");
   endtask

   task automatic t_frame;
      int n;
      frames(1);
      @(posedge clk);
      n = 1;
      while (fstart !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk(n, 192);
      $display("test frame done");
   endtask

   task automatic t_ctrl;
      frames(2);
      chk(ctrl_seen, 12'h249);
      wr(ADDR_CTRL, 32'h0f1);
      rd(ADDR_STATUS);
      chk(d[15:12], 4'he);
      frames(2);
      chk(ctrl_seen, 12'h0f1);
      rd(ADDR_STATUS);
      chk(d[15:12], 4'h0);
      $display("test control done");
   endtask

   task automatic t_sym;
      frames(1);
      wr(ADDR_SYM, 32'h3175);
      wr(ADDR_SYM, 32'h6420);
      afe_u.hist.delete();
      frames(4);
      chk(afe_u.hist[1], 12'h4c8);
      chk(afe_u.hist[2] & 12'h924, 12'h924);
      $display("test symbols done");
   endtask

   // Ninth push lands on a full buffer and must be dropped and flagged
   task automatic t_fill;
      frames(1);
      repeat (9) wr(ADDR_SYM, 32'h0);
      rd(ADDR_STATUS);
      chk(d & 32'hf0600, 32'h80600);
      chk(tx_ready, 1'b0);
      rd(ADDR_SYM);
      chk(d[3:0], 4'h8);
      wr(ADDR_STATUS, 32'h200);
      rd(ADDR_STATUS);
      chk(d[9], 1'b0);
      frames(9);
      rd(ADDR_STATUS);
      chk(d & 32'hf0400, 32'h0);
      chk(tx_ready, 1'b1);
      $display("test buffer done");
   endtask

   task automatic t_wake;
      wake_on <= 4'h5;
      frames(3);
      chk(wake, 4'h5);
      rd(ADDR_STATUS);
      chk({d[8], d[3:0]}, 5'h05);
      wake_on <= 4'ha;
      frames(3);
      chk(wake, 4'ha);
      $display("test wake done");
   endtask

   task automatic t_adc;
      rd(ADDR_ADC);
      chk(d, 32'hc0402010);
      chk(errs, 16'h0);
      $display("test converter done");
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      t_reset;
      t_frame;
      t_ctrl;
      t_sym;
      t_fill;
      t_wake;
      t_adc;
      close_out;
   end

   // About 27 frames are needed; the ceiling leaves ample margin
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         close_out;
      end
   end
endmodule // test_ats_link
